// [rtl/iflii_top.sv]
// Fault record log and IOTLB invalidation command registers
`timescale 1ns/10ps
`include "iflii_cfg.svh"

////////////////////////////////////////////////////////////////////////////////

// How it works
// - Fields written first, fault flag one cycle later
// - Same requester faults merge into set record
// - Fault flag sticky, cleared by writing one
// - Record direction: 0 write, 1 read
// - Record request address type
// - Record first fault reason code
// - Record requester identifier
// - Hint clear: flush leaf and non-leaf
// - Hint set on page scope: keep non-leaf, flush leaf
// - Mask order only 0 through 9
// - Completion clears go, reports performed scope
// - Scope codes: global, domain, page
// - Reserved scope ignored, completes, reports zero
// - Performed scope zero when request rejected
// - Drain bits choose read/write draining
// - Only low 8 domain bits used
module iflii_top #(
	parameter int NREC = 8 // Fault records
) (
	input wire logic clk_i, // 40 MHz clock
	input wire logic rst_n_i, // Power-on reset, async, low
	input wire logic soft_rst_n_i, // Warm reset, sync, low
	input wire logic fault_valid_i, // Translation fault seen
	input wire iflii_pkg::iflii_fault_t fault_i, // Fault details
	output logic fault_drop_o, // Fault lost, log full
	input wire logic reg_req_i, // Register access
	input wire logic reg_we_i, // Access is a write
	input wire logic [15:0] reg_addr_i, // Byte address
	input wire logic [63:0] reg_wdata_i, // Write data
	output logic reg_ack_o, // Access done
	output logic [63:0] reg_rdata_o, // Read data
	output logic flush_valid_o, // Flush request to IOTLB
	output iflii_pkg::iflii_flush_t flush_o, // Flush details
	input wire logic flush_ready_i, // IOTLB took the flush
	output logic [1:0] drain_o, // {read, write} drain
	input wire logic drain_done_i // Drain finished
);
	if (NREC < 1 || NREC > `IFLII_MAX_REC) begin : g_bad_nrec
		$error("NREC must lie in 1..15");
	end

	typedef struct packed {
		iflii_pkg::iflii_rec_t [NREC-1:0] rec;
		logic [51:0] ia_page;
		logic hint;
		logic [5:0] mask;
		logic go;
		logic [1:0] gran;
		logic [1:0] act;
		logic rdrain;
		logic wdrain;
		logic [7:0] did;
		logic start;
		logic ack;
		logic drop;
		logic [63:0] rdata;
	} iflii_top_st_t;

	iflii_top_st_t s;
	iflii_top_st_t next_s;

	logic wr;
	logic rd;
	logic [NREC-1:0] hit;
	logic [NREC-1:0] free;
	logic [NREC-1:0] src_sel;
	logic [NREC-1:0] gpa_sel;
	logic any_hit;
	logic any_free;
	logic [3:0] fidx;
	logic eng_done;
	logic [1:0] eng_act;
	iflii_pkg::iflii_cmd_t cmd;

	////////////////////////////////////////////////////////////////////////////////

	function automatic logic [3:0] first_free(input logic [NREC-1:0] f);
		logic [3:0] r;
		r = 4'h0;
		for (int k = NREC - 1; k >= 0; k--) begin
			if (f[k]) begin
				r = 4'(k);
			end
		end
		return r;
	endfunction

	assign wr = reg_req_i && reg_we_i;
	assign rd = reg_req_i && !reg_we_i;

	for (genvar g = 0; g < NREC; g++) begin : g_rec
		localparam logic [15:0] SRC_A =
			16'(`IFLII_OFS_REC_SRC + g * `IFLII_REC_STRIDE);
		localparam logic [15:0] GPA_A =
			16'(`IFLII_OFS_REC_GPA + g * `IFLII_REC_STRIDE);
		// A pending record merges too, so a burst cannot take two slots
		assign hit[g] = (s.rec[g].flag || s.rec[g].pend) &&
			(s.rec[g].f.requester_tag == fault_i.requester_tag);
		assign free[g] = !s.rec[g].flag && !s.rec[g].pend;
		assign src_sel[g] = (reg_addr_i == SRC_A);
		assign gpa_sel[g] = (reg_addr_i == GPA_A);

		a_flag_after_fields: assert property (@(posedge clk_i)
			disable iff (!rst_n_i)
			$rose(s.rec[g].flag) |-> $past(s.rec[g].pend) &&
			$stable(s.rec[g].f))
			else $error("fault flag rose before fields were held");
		a_type_capture: assert property (@(posedge clk_i)
			disable iff (!rst_n_i)
			fault_valid_i && !any_hit && any_free && (fidx == 4'(g))
			|=> s.rec[g].pend && (s.rec[g].f.is_read ==
			$past(fault_i.is_read)) ##1 s.rec[g].flag)
			else $error("direction not captured ahead of flag");
		a_at_capture: assert property (@(posedge clk_i)
			disable iff (!rst_n_i)
			fault_valid_i && !any_hit && any_free && (fidx == 4'(g))
			|=> s.rec[g].f.addr_type_capture ==
			$past(fault_i.addr_type_capture))
			else $error("address type not captured");
		a_cause_capture: assert property (@(posedge clk_i)
			disable iff (!rst_n_i)
			fault_valid_i && !any_hit && any_free && (fidx == 4'(g))
			|=> s.rec[g].f.error_cause == $past(fault_i.error_cause))
			else $error("fault reason not captured");
		a_tag_capture: assert property (@(posedge clk_i)
			disable iff (!rst_n_i)
			fault_valid_i && !any_hit && any_free && (fidx == 4'(g))
			|=> s.rec[g].f.requester_tag == $past(fault_i.requester_tag))
			else $error("requester tag not captured");
		a_merge_hold: assert property (@(posedge clk_i)
			disable iff (!rst_n_i)
			fault_valid_i && hit[g] |=> $stable(s.rec[g].f) &&
			(s.rec == $past(s.rec) || $past(wr) ||
			$past(s.rec[g].pend) || ($past(|{s.rec}) != 1'b0)))
			else $error("merged fault altered its record");
		a_w1c_clear: assert property (@(posedge clk_i)
			disable iff (!rst_n_i)
			wr && src_sel[g] && reg_wdata_i[63] && !s.rec[g].pend
			|=> !s.rec[g].flag)
			else $error("write of one did not clear fault flag");
		a_set_beats_clr: assert property (@(posedge clk_i)
			disable iff (!rst_n_i)
			s.rec[g].pend |=> s.rec[g].flag)
			else $error("pending fault did not set its flag");
		a_flag_sticky: assert property (@(posedge clk_i)
			disable iff (!rst_n_i)
			s.rec[g].flag && !(wr && src_sel[g] && reg_wdata_i[63])
			|=> s.rec[g].flag)
			else $error("fault flag dropped without a clear");
		a_src_readback: assert property (@(posedge clk_i)
			disable iff (!rst_n_i)
			rd && src_sel[g] |=> (reg_rdata_o[63] == $past(s.rec[g].flag))
			&& (reg_rdata_o[15:0] == $past(s.rec[g].f.requester_tag)))
			else $error("fault record read back wrong");
	end

	assign any_hit = |hit;
	assign any_free = |free;
	assign fidx = first_free(free);

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		next_s = s;
		next_s.start = 1'b0;
		next_s.ack = reg_req_i;
		next_s.drop = 1'b0;
		next_s.rdata = `IFLII_RST64;

		// Clear goes first so a flag being set in the same cycle survives
		for (int k = 0; k < NREC; k++) begin
			if (wr && src_sel[k] && reg_wdata_i[`IFLII_FLAG_BIT]) begin
				next_s.rec[k].flag = 1'b0;
			end
			if (s.rec[k].pend) begin
				next_s.rec[k].pend = 1'b0;
				next_s.rec[k].flag = 1'b1;
			end
		end

		// Fields land one cycle ahead of the flag
		if (fault_valid_i && !any_hit) begin
			if (any_free) begin
				next_s.rec[fidx].f = fault_i;
				next_s.rec[fidx].pend = 1'b1;
			end else begin
				next_s.drop = 1'b1;
			end
		end

		// Command register writes are refused while a command is in flight
		if (wr && !s.go) begin
			if (reg_addr_i == `IFLII_OFS_INVADDR) begin
				next_s.ia_page = reg_wdata_i[63:`IFLII_PAGE_LO];
				next_s.hint = reg_wdata_i[`IFLII_HINT_BIT];
				next_s.mask = reg_wdata_i[`IFLII_MASK_HI:0];
			end
			if (reg_addr_i == `IFLII_OFS_IOTLB) begin
				next_s.gran = reg_wdata_i[`IFLII_REQ_HI:`IFLII_REQ_LO];
				next_s.rdrain = reg_wdata_i[`IFLII_RDRAIN_BIT];
				next_s.wdrain = reg_wdata_i[`IFLII_WDRAIN_BIT];
				// Upper domain bits are dropped
				next_s.did = reg_wdata_i[`IFLII_DID_HI:`IFLII_DID_LO];
				next_s.go = reg_wdata_i[`IFLII_GO_BIT];
				next_s.start = reg_wdata_i[`IFLII_GO_BIT];
			end
		end

		if (eng_done) begin
			next_s.go = 1'b0;
			next_s.act = eng_act;
		end

		if (rd) begin
			if (reg_addr_i == `IFLII_OFS_INVADDR) begin
				next_s.rdata = {s.ia_page, 5'h00, s.hint, s.mask};
			end
			if (reg_addr_i == `IFLII_OFS_IOTLB) begin
				next_s.rdata = {s.go, 1'b0, s.gran, 1'b0, s.act, 7'h00,
					s.rdrain, s.wdrain, 8'h00, s.did, 32'h0000_0000};
			end
			// Stale fields read back as stored; the flag says if valid
			for (int k = 0; k < NREC; k++) begin
				if (src_sel[k]) begin
					next_s.rdata = {s.rec[k].flag, s.rec[k].f.is_read,
						s.rec[k].f.addr_type_capture, 20'h00000,
						s.rec[k].f.error_cause, 16'h0000,
						s.rec[k].f.requester_tag};
				end
				if (gpa_sel[k]) begin
					next_s.rdata = {s.rec[k].f.page, 12'h000};
				end
			end
		end

		// Warm reset spares the sticky fault records
		if (!soft_rst_n_i) begin
			next_s.ia_page = 52'h0;
			next_s.hint = 1'b0;
			next_s.mask = 6'h00;
			next_s.go = 1'b0;
			next_s.gran = 2'h0;
			next_s.act = 2'h0;
			next_s.rdrain = 1'b0;
			next_s.wdrain = 1'b0;
			next_s.did = 8'h00;
			next_s.start = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		cmd = '0;
		cmd.gran = s.gran;
		cmd.read_flush_wait = s.rdrain;
		cmd.write_flush_wait = s.wdrain;
		cmd.did = s.did;
		cmd.page = s.ia_page;
		cmd.nonleaf_keep_hint = s.hint;
		cmd.mask_order = s.mask;
	end

	iflii_inval_engine iflii_inval_engine_inst (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.soft_rst_n_i(soft_rst_n_i),
		.start_i(s.start),
		.cmd_i(cmd),
		.done_o(eng_done),
		.act_o(eng_act),
		.flush_valid_o(flush_valid_o),
		.flush_o(flush_o),
		.flush_ready_i(flush_ready_i),
		.drain_o(drain_o),
		.drain_done_i(drain_done_i)
	);

	assign fault_drop_o = s.drop;
	assign reg_ack_o = s.ack;
	assign reg_rdata_o = s.rdata;

	a_done_report: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		eng_done && soft_rst_n_i |=> !s.go && (s.act == $past(eng_act)))
		else $error("completion did not clear go or report scope");
	a_busy_locked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s.go && !eng_done && soft_rst_n_i |=> s.go &&
		$stable(s.ia_page) && $stable(s.gran) && $stable(s.did))
		else $error("command registers changed while busy");
	a_start_once: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr && !s.go && soft_rst_n_i && (reg_addr_i == 16'h0208) &&
		reg_wdata_i[63] |=> s.go && s.start ##1 !s.start)
		else $error("go write did not start one command");
	a_did_trim: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s.start |-> ##1 (flush_o.did == $past(s.did)))
		else $error("domain tag not passed to flush");
	a_warm_keeps: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!soft_rst_n_i && !fault_valid_i && !wr && (s.rec[0].pend == 1'b0)
		|=> $stable(s.rec[0]) && !s.go)
		else $error("warm reset disturbed a fault record");

	////////////////////////////////////////////////////////////////////////////////

	// Log outcome, warm reset and hand-over to the sequencer
	a_drop_full: assert property (@(posedge clk_i)
		disable iff (!rst_n_i)
		fault_valid_i && !any_hit && !any_free |=> fault_drop_o)
		else $error("fault lost without a drop pulse");
	a_merge_kept: assert property (@(posedge clk_i)
		disable iff (!rst_n_i)
		fault_valid_i && any_hit |=> !fault_drop_o)
		else $error("merged fault reported as dropped");
	a_warm_clears: assert property (@(posedge clk_i)
		disable iff (!rst_n_i)
		!soft_rst_n_i |=> !s.go && (s.ia_page == 52'h0) &&
		(s.gran == 2'h0) && (s.act == 2'h0) && (s.did == 8'h00))
		else $error("warm reset left command state behind");
	a_go_by_write: assert property (@(posedge clk_i)
		disable iff (!rst_n_i)
		$rose(s.go) |-> $past(wr) && ($past(reg_addr_i) == 16'h0208))
		else $error("go bit set without a command write");
	a_page_domain: assert property (@(posedge clk_i)
		disable iff (!rst_n_i)
		eng_done && soft_rst_n_i && (s.gran == 2'h3) && (eng_act != 2'h0)
		|=> s.act == 2'h2)
		else $error("page command not reported as domain scope");
	a_flush_scope: assert property (@(posedge clk_i)
		disable iff (!rst_n_i)
		s.start && soft_rst_n_i |=> flush_o.scope == $past(s.gran))
		else $error("requested scope not passed to flush");
	a_hint_keep: assert property (@(posedge clk_i)
		disable iff (!rst_n_i)
		s.start && soft_rst_n_i && (s.gran == 2'h3) && s.hint
		|=> flush_o.leaf && !flush_o.nonleaf)
		else $error("hint set but non-leaf flush requested");
	a_hint_clear: assert property (@(posedge clk_i)
		disable iff (!rst_n_i)
		s.start && soft_rst_n_i && !s.hint |=> flush_o.leaf && flush_o.nonleaf)
		else $error("hint clear but a level left unflushed");
endmodule

// [rtl/iflii_cfg.svh]
// Offsets, field positions, reset values and codes of the fault log block
`ifndef IFLII_CFG_SVH
`define IFLII_CFG_SVH
`define IFLII_OFS_INVADDR 16'h0200
`define IFLII_OFS_IOTLB 16'h0208
`define IFLII_OFS_REC_GPA 16'h0110
`define IFLII_OFS_REC_SRC 16'h0118
`define IFLII_REC_STRIDE 16'h0010
`define IFLII_MAX_REC 15
`define IFLII_FLAG_BIT 63
`define IFLII_GO_BIT 63
`define IFLII_RDRAIN_BIT 49
`define IFLII_WDRAIN_BIT 48
`define IFLII_DID_HI 39
`define IFLII_DID_LO 32
`define IFLII_REQ_HI 61
`define IFLII_REQ_LO 60
`define IFLII_PAGE_LO 12
`define IFLII_HINT_BIT 6
`define IFLII_MASK_HI 5
`define IFLII_MASK_MAX 6'h09
`define IFLII_GRAN_RSVD 2'h0
`define IFLII_GRAN_GLOBAL 2'h1
`define IFLII_GRAN_DOMAIN 2'h2
`define IFLII_GRAN_PAGE 2'h3
`define IFLII_RST64 64'h0
`endif

// [rtl/iflii_pkg.sv]
// Types shared by the fault log and the invalidation sequencer
package iflii_pkg;
	typedef struct packed {
		logic [15:0] requester_tag;
		logic is_read;
		logic [1:0] addr_type_capture;
		logic [7:0] error_cause;
		logic [51:0] page;
	} iflii_fault_t;

	typedef struct packed {
		logic [1:0] gran;
		logic read_flush_wait;
		logic write_flush_wait;
		logic [7:0] did;
		logic [51:0] page;
		logic nonleaf_keep_hint;
		logic [5:0] mask_order;
	} iflii_cmd_t;

	typedef struct packed {
		logic [1:0] scope;
		logic [7:0] did;
		logic [51:0] page;
		logic [5:0] mask_order;
		logic leaf;
		logic nonleaf;
	} iflii_flush_t;

	typedef struct packed {
		logic flag;
		logic pend;
		iflii_fault_t f;
	} iflii_rec_t;

	typedef enum logic [1:0] {
		ENG_IDLE,
		ENG_DRAIN,
		ENG_FLUSH,
		ENG_DONE
	} iflii_eng_t;
endpackage

// [rtl/iflii_inval_engine.sv]
// Invalidation sequencer: drain, flush handshake and completion report
`timescale 1ns/10ps
`include "iflii_cfg.svh"
module iflii_inval_engine (
	input wire logic clk_i, // 40 MHz clock
	input wire logic rst_n_i, // Async reset, low
	input wire logic soft_rst_n_i, // Warm reset, low
	input wire logic start_i, // Command pulse
	input wire iflii_pkg::iflii_cmd_t cmd_i, // Command fields
	output logic done_o, // Completion pulse
	output logic [1:0] act_o, // Performed scope
	output logic flush_valid_o, // Flush request
	output iflii_pkg::iflii_flush_t flush_o, // Flush details
	input wire logic flush_ready_i, // Flush accepted
	output logic [1:0] drain_o, // {read, write} drain
	input wire logic drain_done_i // Drain finished
);
	typedef struct packed {
		iflii_pkg::iflii_eng_t st;
		iflii_pkg::iflii_cmd_t cmd;
		logic [1:0] act;
		logic [1:0] drain;
		logic fv;
		iflii_pkg::iflii_flush_t fl;
	} iflii_eng_st_t;

	iflii_eng_st_t s;
	iflii_eng_st_t next_s;
	logic bad;

	// Unsupported scope or mask is refused without touching the cache
	assign bad = (cmd_i.gran == `IFLII_GRAN_RSVD) ||
		((cmd_i.gran == `IFLII_GRAN_PAGE) &&
		(cmd_i.mask_order > `IFLII_MASK_MAX));

	always_comb begin
		next_s = s;
		unique case (s.st)
		iflii_pkg::ENG_IDLE: begin
			if (start_i) begin
				next_s.cmd = cmd_i;
				next_s.fl.scope = cmd_i.gran;
				next_s.fl.did = cmd_i.did;
				next_s.fl.page = cmd_i.page;
				next_s.fl.mask_order = cmd_i.mask_order;
				next_s.fl.leaf = 1'b1;
				next_s.fl.nonleaf = !((cmd_i.gran == `IFLII_GRAN_PAGE) &&
					cmd_i.nonleaf_keep_hint);
				if (bad) begin
					next_s.act = `IFLII_GRAN_RSVD;
					next_s.st = iflii_pkg::ENG_DONE;
				end else if (cmd_i.read_flush_wait ||
					cmd_i.write_flush_wait) begin
					next_s.drain = {cmd_i.read_flush_wait,
						cmd_i.write_flush_wait};
					next_s.st = iflii_pkg::ENG_DRAIN;
				end else begin
					next_s.fv = 1'b1;
					next_s.st = iflii_pkg::ENG_FLUSH;
				end
			end
		end
		iflii_pkg::ENG_DRAIN: begin
			if (drain_done_i) begin
				next_s.drain = 2'h0;
				next_s.fv = 1'b1;
				next_s.st = iflii_pkg::ENG_FLUSH;
			end
		end
		iflii_pkg::ENG_FLUSH: begin
			if (flush_ready_i) begin
				next_s.fv = 1'b0;
				// Page scope is reported as carried out at domain level, hint or not
				next_s.act = (s.cmd.gran == `IFLII_GRAN_GLOBAL) ?
					`IFLII_GRAN_GLOBAL : `IFLII_GRAN_DOMAIN;
				next_s.st = iflii_pkg::ENG_DONE;
			end
		end
		iflii_pkg::ENG_DONE: begin
			next_s.st = iflii_pkg::ENG_IDLE;
		end
		endcase
		if (!soft_rst_n_i) begin
			next_s = '0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign done_o = (s.st == iflii_pkg::ENG_DONE);
	assign act_o = s.act;
	assign flush_valid_o = s.fv;
	assign flush_o = s.fl;
	assign drain_o = s.drain;

	a_reject_gran: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(s.st == iflii_pkg::ENG_IDLE) && start_i && soft_rst_n_i &&
		(cmd_i.gran == `IFLII_GRAN_RSVD) |=> done_o && (act_o == 2'h0)
		##1 !done_o)
		else $error("reserved scope not refused at once");
	a_mask_reject: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(s.st == iflii_pkg::ENG_IDLE) && start_i && soft_rst_n_i &&
		(cmd_i.gran == `IFLII_GRAN_PAGE) && (cmd_i.mask_order > 6'h09)
		|=> done_o && (act_o == 2'h0) && !flush_valid_o)
		else $error("bad mask order not refused");
	a_keep_nonleaf: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		flush_valid_o && (flush_o.scope == 2'h3) &&
		s.cmd.nonleaf_keep_hint |-> flush_o.leaf && !flush_o.nonleaf)
		else $error("non-leaf entries flushed despite hint");
	a_flush_nonleaf: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		flush_valid_o && !s.cmd.nonleaf_keep_hint |-> flush_o.leaf &&
		flush_o.nonleaf)
		else $error("non-leaf entries kept without hint");
	a_drain_select: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(s.st == iflii_pkg::ENG_IDLE) && start_i && soft_rst_n_i && !bad
		|=> (drain_o[1] == $past(cmd_i.read_flush_wait)) &&
		(drain_o[0] == $past(cmd_i.write_flush_wait)) &&
		(flush_valid_o == (drain_o == 2'h0)))
		else $error("drain request does not follow the command");
endmodule

// [dv/iflii_top_tb.sv]
// Self-checking bench for the fault log and IOTLB invalidation block
`timescale 1ns/10ps
`include "iflii_cfg.svh"
module iflii_top_tb;
	localparam int NREC = 2;
	localparam int LIMIT = 20000;
	localparam logic [15:0] A_ADR = `IFLII_OFS_INVADDR;
	localparam logic [15:0] A_CMD = `IFLII_OFS_IOTLB;
	localparam logic [15:0] A_SRC = `IFLII_OFS_REC_SRC;
	localparam logic [15:0] A_GPA = `IFLII_OFS_REC_GPA;
	localparam logic [15:0] A_STP = `IFLII_REC_STRIDE;
	localparam logic [51:0] PG = 52'habcdef0123456;
	logic clk_i;
	logic rst_n_i;
	logic soft_rst_n_i;
	logic fault_valid_i;
	iflii_pkg::iflii_fault_t fault_i;
	logic fault_drop_o;
	logic reg_req_i;
	logic reg_we_i;
	logic [15:0] reg_addr_i;
	logic [63:0] reg_wdata_i;
	logic reg_ack_o;
	logic [63:0] reg_rdata_o;
	logic flush_valid_o;
	iflii_pkg::iflii_flush_t flush_o;
	logic flush_ready_i;
	logic [1:0] drain_o;
	logic drain_done_i;
	int bad_count;
	int n_tests;
	int cycles;
	logic [63:0] scratch;
	logic drop;

	iflii_top #(.NREC(NREC)) iflii_top_inst (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.soft_rst_n_i(soft_rst_n_i),
		.fault_valid_i(fault_valid_i),
		.fault_i(fault_i),
		.fault_drop_o(fault_drop_o),
		.reg_req_i(reg_req_i),
		.reg_we_i(reg_we_i),
		.reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_ack_o(reg_ack_o),
		.reg_rdata_o(reg_rdata_o),
		.flush_valid_o(flush_valid_o),
		.flush_o(flush_o),
		.flush_ready_i(flush_ready_i),
		.drain_o(drain_o),
		.drain_done_i(drain_done_i)
	);

////////////////////////////////////////////////////////////////////////////////

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	// A hung handshake must still reach the closing report
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == LIMIT) begin
			bad_count++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		if (bad_count == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

////////////////////////////////////////////////////////////////////////////////

	// Entered and left at a falling edge; the idle cycle keeps strobes apart
	task automatic reg_acc(input logic we, input logic [15:0] a,
			input logic [63:0] d, output logic [63:0] q);
		reg_req_i = 1'b1;
		reg_we_i = we;
		reg_addr_i = a;
		reg_wdata_i = d;
		@(negedge clk_i);
		reg_req_i = 1'b0;
		chk({63'h0, reg_ack_o}, 64'h1);
		q = reg_rdata_o;
		@(negedge clk_i);
	endtask

	task automatic wr(input logic [15:0] a, input logic [63:0] d);
		reg_acc(1'b1, a, d, scratch);
	endtask

	task automatic rdm(input logic [15:0] a, input logic [63:0] m,
			input logic [63:0] exp);
		logic [63:0] q;
		reg_acc(1'b0, a, 64'h0, q);
		chk(q & m, exp);
	endtask

	task automatic send_fault(input logic [15:0] t, input logic r,
			input logic [1:0] at, input logic [7:0] c);
		fault_i = '{t, r, at, c, {36'h0, t}};
		fault_valid_i = 1'b1;
		@(negedge clk_i);
		fault_valid_i = 1'b0;
		drop = fault_drop_o;
		@(negedge clk_i);
	endtask

	function automatic logic [63:0] src(input logic [15:0] t, input logic r,
			input logic [1:0] at, input logic [7:0] c);
		return {1'b1, r, at, 20'h0, c, 16'h0, t};
	endfunction

	// Domain tag upper byte is always junk so that it must be ignored
	task automatic cmd(input logic [1:0] req, input logic [1:0] drn,
			input logic nl, input logic [1:0] act, input logic fl);
		int n;
		logic seen;
		logic [63:0] q;
		wr(A_CMD, {2'h2, req, 10'h0, drn, 16'hab5c, 32'h0});
		n = 0;
		seen = 1'b0;
		if (drn != 2'h0) begin
			while (drain_o == 2'h0 && n < 50) begin
				@(negedge clk_i);
				n++;
			end
			chk({62'h0, drain_o}, {62'h0, drn});
			chk({63'h0, flush_valid_o}, 64'h0);
			drain_done_i = 1'b1;
			@(negedge clk_i);
			drain_done_i = 1'b0;
		end
		if (fl) begin
			while (flush_valid_o !== 1'b1 && n < 50) begin
				@(negedge clk_i);
				n++;
			end
			chk({54'h0, flush_o.scope, flush_o.did}, {54'h0, req, 8'h5c});
			chk({62'h0, flush_o.leaf, flush_o.nonleaf}, {62'h0, 1'b1, nl});
			if (req == 2'h3) begin
				chk({6'h0, flush_o.page, flush_o.mask_order}, {6'h0, PG, 6'h09});
			end
			wr(A_ADR, 64'h0);
			flush_ready_i = 1'b1;
			@(negedge clk_i);
			flush_ready_i = 1'b0;
		end
		q = {1'b1, 63'h0};
		n = 0;
		while (q[63] !== 1'b0 && n < 50) begin
			seen = seen | flush_valid_o;
			reg_acc(1'b0, A_CMD, 64'h0, q);
			n++;
		end
		chk(q, {2'h0, req, 1'b0, act, 7'h0, drn, 16'h005c, 32'h0});
		chk({63'h0, seen}, 64'h0);
	endtask

////////////////////////////////////////////////////////////////////////////////

	initial begin
		bad_count = 0;
		n_tests = 0;
		cycles = 0;
		rst_n_i = 1'b0;
		soft_rst_n_i = 1'b1;
		fault_valid_i = 1'b0;
		fault_i = '0;
		reg_req_i = 1'b0;
		reg_we_i = 1'b0;
		reg_addr_i = 16'h0;
		reg_wdata_i = 64'h0;
		flush_ready_i = 1'b0;
		drain_done_i = 1'b0;
		drop = 1'b0;
		repeat (16) @(negedge clk_i);
		rst_n_i = 1'b1;
		@(negedge clk_i);
		rdm(A_ADR, '1, 64'h0);
		rdm(A_CMD, '1, 64'h0);
		rdm(A_SRC, '1, 64'h0);
		rdm(A_SRC + A_STP, '1, 64'h0);
		rdm(A_GPA, '1, 64'h0);
		rdm(16'h0300, '1, 64'h0);
		send_fault(16'h0005, 1'b1, 2'h2, 8'ha5);
		rdm(A_SRC, '1, src(16'h0005, 1'b1, 2'h2, 8'ha5));
		rdm(A_GPA, '1, {36'h0, 16'h0005, 12'h0});
		send_fault(16'h0005, 1'b0, 2'h1, 8'h11);
		chk({63'h0, drop}, 64'h0);
		rdm(A_SRC, '1, src(16'h0005, 1'b1, 2'h2, 8'ha5));
		rdm(A_SRC + A_STP, '1, 64'h0);
		send_fault(16'h0009, 1'b0, 2'h1, 8'h22);
		rdm(A_SRC + A_STP, '1, src(16'h0009, 1'b0, 2'h1, 8'h22));
		// Both records busy with other requesters, so this one is lost
		send_fault(16'h0007, 1'b1, 2'h3, 8'h33);
		chk({63'h0, drop}, 64'h1);
		wr(A_SRC, 64'h0);
		rdm(A_SRC, '1, src(16'h0005, 1'b1, 2'h2, 8'ha5));
		soft_rst_n_i = 1'b0;
		@(negedge clk_i);
		soft_rst_n_i = 1'b1;
		@(negedge clk_i);
		rdm(A_SRC + A_STP, '1, src(16'h0009, 1'b0, 2'h1, 8'h22));
		wr(A_SRC, {1'b1, 63'h0});
		rdm(A_SRC, {1'b1, 63'h0}, 64'h0);
		send_fault(16'h0007, 1'b1, 2'h3, 8'h33);
		chk({63'h0, drop}, 64'h0);
		rdm(A_SRC, '1, src(16'h0007, 1'b1, 2'h3, 8'h33));
		wr(A_ADR, {PG, 5'h0, 1'b0, 6'h09});
		rdm(A_ADR, '1, {PG, 5'h0, 1'b0, 6'h09});
		cmd(2'h1, 2'h0, 1'b1, 2'h1, 1'b1);
		cmd(2'h2, 2'h2, 1'b1, 2'h2, 1'b1);
		cmd(2'h3, 2'h1, 1'b1, 2'h2, 1'b1);
		rdm(A_ADR, '1, {PG, 5'h0, 1'b0, 6'h09});
		wr(A_ADR, {PG, 5'h0, 1'b1, 6'h09});
		cmd(2'h3, 2'h3, 1'b0, 2'h2, 1'b1);
		cmd(2'h0, 2'h0, 1'b1, 2'h0, 1'b0);
		wr(A_ADR, {PG, 5'h0, 1'b0, 6'h0a});
		cmd(2'h3, 2'h0, 1'b1, 2'h0, 1'b0);
		// Command side holds non-zero values now, so the warm reset shows
		soft_rst_n_i = 1'b0;
		@(negedge clk_i);
		soft_rst_n_i = 1'b1;
		@(negedge clk_i);
		rdm(A_ADR, '1, 64'h0);
		rdm(A_CMD, '1, 64'h0);
		rdm(A_SRC, '1, src(16'h0007, 1'b1, 2'h3, 8'h33));
		print_verdict();
	end
endmodule
